//--- rtmc_pkg.sv
package rtmc_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_TERM_OP_STATUS = 8'h18;
    localparam int TA_MSB = 15;
    localparam int TA_LSB = 11;
    localparam int TAP_BIT = 10;
    localparam int LOCK_BIT = 9;
    localparam int HOSTW_LSB = 9;
    localparam int TYPE_MSB = 5;
    localparam int TYPE_LSB = 3;
    localparam int APF_BIT = 2;
    localparam logic [15:0] OP_STATUS_RESET = 16'h0000;

    // ----------------------------------------
    // sync option field codes
    // ----------------------------------------
    localparam logic [1:0] SYNC_HOST = 2'b00;
    localparam logic [1:0] SYNC_IF_BIT0_LO = 2'b01;
    localparam logic [1:0] SYNC_IF_BIT0_HI = 2'b10;
    localparam logic [1:0] SYNC_ALWAYS = 2'b11;

    // ----------------------------------------
    // command word fields and codes
    // ----------------------------------------
    localparam int CW_TR_BIT = 10;
    localparam int CW_SA_MSB = 9;
    localparam int CW_SA_LSB = 5;
    localparam int CW_MC_MSB = 4;
    localparam int CW_MC_LSB = 0;
    localparam logic [4:0] SA_MODE_LO = 5'h00;
    localparam logic [4:0] SA_MODE_HI = 5'h1f;
    localparam logic [4:0] MC_SYNC_DATA = 5'h11;
    localparam logic [4:0] MC_TX_VECTOR = 5'h10;
    localparam logic [4:0] MC_RESET_RT = 5'h08;
    localparam int MC_HI_BIT = 4;

    localparam logic [2:0] CT_SUBADDR = 3'b000;
    localparam logic [2:0] CT_NO_DATA = 3'b100;
    localparam logic [2:0] CT_RX_DATA = 3'b010;
    localparam logic [2:0] CT_TX_DATA = 3'b001;
    localparam logic [2:0] CT_UNDEF = 3'b111;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CUR_CMD_DELAY_NS = 5000;
    localparam int CUR_CMD_DELAY_CYC = CUR_CMD_DELAY_NS / CLK_PERIOD_NS;
    localparam int DLY_W = 7;
    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(CUR_CMD_DELAY_CYC - 1);
    localparam logic [DLY_W-1:0] DLY_ZERO = 7'h00;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } rtmc_host_req_t;

    typedef struct packed {
        logic valid;
        logic broadcast;
        logic [15:0] word;
    } rtmc_cmd_t;

    typedef struct packed {
        logic [2:0] type_bits;
        logic sync_rx;
        logic vector_tx;
        logic reset_tx;
    } rtmc_decoded_t;

    typedef enum logic [1:0] {
        RTMC_SR_IDLE = 2'b00,
        RTMC_SR_WAIT = 2'b01,
        RTMC_SR_FIRE = 2'b11
    } rtmc_sr_state_t;

endpackage

//--- rtmc_cmd_decode.sv
module rtmc_cmd_decode (
    input wire logic [15:0] cmd_word,
    output rtmc_pkg::rtmc_decoded_t dec
);

    wire logic [4:0] sa = cmd_word[rtmc_pkg::CW_SA_MSB:rtmc_pkg::CW_SA_LSB];
    wire logic [4:0] mc = cmd_word[rtmc_pkg::CW_MC_MSB:rtmc_pkg::CW_MC_LSB];
    wire logic tx = cmd_word[rtmc_pkg::CW_TR_BIT];
    wire logic is_mode = (sa == rtmc_pkg::SA_MODE_LO) || (sa == rtmc_pkg::SA_MODE_HI);
    wire logic mc_hi = mc[rtmc_pkg::MC_HI_BIT];

    wire logic [2:0] mode_type = mc_hi ? (tx ? rtmc_pkg::CT_TX_DATA : rtmc_pkg::CT_RX_DATA)
                                      : (tx ? rtmc_pkg::CT_NO_DATA : rtmc_pkg::CT_UNDEF);

    wire logic [2:0] type_bits = is_mode ? mode_type : rtmc_pkg::CT_SUBADDR;
    wire logic sync_rx = is_mode && !tx && (mc == rtmc_pkg::MC_SYNC_DATA);
    wire logic vector_tx = is_mode && tx && (mc == rtmc_pkg::MC_TX_VECTOR);
    wire logic reset_tx = is_mode && tx && (mc == rtmc_pkg::MC_RESET_RT);

    // one driver for the whole carrier, not one per member
    assign dec = {type_bits, sync_rx, vector_tx, reset_tx};

endmodule

//--- rtmc_mode_status.sv
module rtmc_mode_status (
    input wire logic clock,
    input wire logic rstn,
    // strap pins, caught at master reset release
    input wire logic [4:0] terminal_address_bits,
    input wire logic terminal_address_parity,
    input wire logic address_lock_pin,
    // option bits from the terminal configuration
    input wire logic [1:0] sync_load_option,
    input wire logic vector_word_option,
    input wire logic reset_command_option,
    // host register access
    input rtmc_pkg::rtmc_host_req_t host_req,
    output logic [15:0] host_rdata,
    // protocol engine events
    input rtmc_pkg::rtmc_cmd_t cmd,
    input wire logic mode_data_valid,
    input wire logic [15:0] mode_data_word,
    input wire logic status_tx_req,
    input wire logic status_tx_done,
    output logic status_tx_go,
    // automatic actions
    output logic time_tag_load,
    output logic [15:0] time_tag_value,
    output logic service_request_clear,
    output logic soft_reset_signal,
    output logic [5:0] terminal_address_out
);

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    rtmc_pkg::rtmc_decoded_t dec;

    rtmc_cmd_decode u_decode (
        .cmd_word(cmd.word),
        .dec(dec)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic strap_done_q;
    logic [6:0] host_bits_q;
    logic [6:0] host_bits_d;
    logic [2:0] type_q;
    logic [2:0] type_pend_q;
    logic dly_run_q;
    logic [rtmc_pkg::DLY_W-1:0] dly_cnt_q;
    logic apf_q;
    logic sync_armed_q;
    logic sync_bcast_q;
    logic tx_pend_q;
    logic load_q;
    logic [15:0] load_val_q;
    logic src_q;
    logic go_q;
    logic [15:0] rdata_q;
    rtmc_pkg::rtmc_sr_state_t sr_q;
    rtmc_pkg::rtmc_sr_state_t sr_d;
    logic soft_q;

    // ----------------------------------------
    // address, parity and lock
    // ----------------------------------------
    wire logic lock = host_bits_q[rtmc_pkg::LOCK_BIT - rtmc_pkg::HOSTW_LSB];
    wire logic hit = host_req.addr == rtmc_pkg::ADDR_TERM_OP_STATUS;
    wire logic host_wr_ok = host_req.wr && hit && !lock;
    wire logic [6:0] strap_bits = {terminal_address_bits, terminal_address_parity, address_lock_pin};

    // lock pin low at master reset is how the outside party unlocks
    assign host_bits_d = !strap_done_q ? strap_bits
                       : host_wr_ok ? host_req.wdata[15:rtmc_pkg::HOSTW_LSB]
                       : host_bits_q;

    // odd parity over address plus parity bit
    wire logic parity_bad = ~^host_bits_d[6:1];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strap_done_q <= 1'b0;
            host_bits_q <= 7'h00;
            apf_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
            host_bits_q <= host_bits_d;
            apf_q <= parity_bad;
        end
    end

    // ----------------------------------------
    // current command type, delayed
    // ----------------------------------------
    // a newer command restarts the wait so the flags track the last one
    wire logic dly_hit = dly_run_q && (dly_cnt_q == rtmc_pkg::DLY_LAST);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dly_run_q <= 1'b0;
            dly_cnt_q <= rtmc_pkg::DLY_ZERO;
            type_pend_q <= rtmc_pkg::CT_SUBADDR;
            type_q <= rtmc_pkg::CT_SUBADDR;
        end else begin
            if (cmd.valid) begin
                dly_run_q <= 1'b1;
                dly_cnt_q <= rtmc_pkg::DLY_ZERO;
                type_pend_q <= dec.type_bits;
            end else if (dly_hit) begin
                dly_run_q <= 1'b0;
            end else if (dly_run_q) begin
                dly_cnt_q <= dly_cnt_q + 1'b1;
            end
            if (dly_hit && !cmd.valid) begin
                type_q <= type_pend_q;
            end
        end
    end

    // ----------------------------------------
    // synchronize with data
    // ----------------------------------------
    wire logic bit0 = mode_data_word[0];
    wire logic opt_ok = (sync_load_option == rtmc_pkg::SYNC_ALWAYS)
                      || ((sync_load_option == rtmc_pkg::SYNC_IF_BIT0_LO) && !bit0)
                      || ((sync_load_option == rtmc_pkg::SYNC_IF_BIT0_HI) && bit0);
    // option 00 never loads; status release below is unchanged
    wire logic do_load = sync_armed_q && mode_data_valid && opt_ok;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync_armed_q <= 1'b0;
            sync_bcast_q <= 1'b0;
            load_q <= 1'b0;
            load_val_q <= 16'h0000;
        end else begin
            if (cmd.valid) begin
                sync_armed_q <= dec.sync_rx;
                sync_bcast_q <= cmd.broadcast;
            end else if (mode_data_valid) begin
                sync_armed_q <= 1'b0;
            end
            load_q <= do_load;
            if (do_load) begin
                load_val_q <= mode_data_word;
            end
        end
    end

    // ----------------------------------------
    // status word release
    // ----------------------------------------
    // held back from a non-broadcast sync command until its data word arrives, and in
    // any load cycle, so the counter is written before the first status bit leaves
    wire logic load_busy = do_load || (sync_armed_q && !sync_bcast_q);
    wire logic tx_want = status_tx_req || tx_pend_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tx_pend_q <= 1'b0;
            go_q <= 1'b0;
        end else begin
            go_q <= tx_want && !load_busy;
            tx_pend_q <= tx_want && load_busy;
        end
    end

    // ----------------------------------------
    // transmit vector word
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            src_q <= 1'b0;
        end else begin
            // clears with the command, ahead of any status request
            src_q <= cmd.valid && dec.vector_tx && !vector_word_option;
        end
    end

    // ----------------------------------------
    // reset remote terminal
    // ----------------------------------------
    wire logic rst_cmd = cmd.valid && dec.reset_tx && !reset_command_option;

    always_comb begin
        sr_d = sr_q;
        unique case (sr_q)
            rtmc_pkg::RTMC_SR_IDLE: begin
                if (rst_cmd) begin
                    sr_d = cmd.broadcast ? rtmc_pkg::RTMC_SR_FIRE : rtmc_pkg::RTMC_SR_WAIT;
                end
            end
            rtmc_pkg::RTMC_SR_WAIT: begin
                if (status_tx_done) begin
                    sr_d = rtmc_pkg::RTMC_SR_FIRE;
                end
            end
            rtmc_pkg::RTMC_SR_FIRE: begin
                sr_d = rtmc_pkg::RTMC_SR_IDLE;
            end
            default: begin
                sr_d = rtmc_pkg::RTMC_SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sr_q <= rtmc_pkg::RTMC_SR_IDLE;
            soft_q <= 1'b0;
        end else begin
            sr_q <= sr_d;
            // own flop so the pin carries no decode glitch
            soft_q <= (sr_d == rtmc_pkg::RTMC_SR_FIRE);
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    // bits 8..6 and 1..0 stay zero
    wire logic [15:0] op_status = {host_bits_q, 3'b000, type_q, apf_q, 2'b00};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= rtmc_pkg::OP_STATUS_RESET;
        end else begin
            rdata_q <= (host_req.rd && hit) ? op_status : 16'h0000;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign host_rdata = rdata_q;
    assign status_tx_go = go_q;
    assign time_tag_load = load_q;
    assign time_tag_value = load_val_q;
    assign service_request_clear = src_q;
    assign soft_reset_signal = soft_q;
    assign terminal_address_out = host_bits_q[6:1];

endmodule

//--- rtmc_mode_status_monitor.sv
module rtmc_mode_status_mon (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [1:0] sync_load_option,
    input wire logic vector_word_option,
    input wire logic reset_command_option,
    input rtmc_pkg::rtmc_host_req_t host_req,
    input wire logic [15:0] host_rdata,
    input rtmc_pkg::rtmc_cmd_t cmd,
    input wire logic mode_data_valid,
    input wire logic [15:0] mode_data_word,
    input wire logic status_tx_go,
    input wire logic time_tag_load,
    input wire logic [15:0] time_tag_value,
    input wire logic service_request_clear,
    input wire logic soft_reset_signal
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_load_from_data: assert property (time_tag_load |-> $past(mode_data_valid) && time_tag_value == $past(mode_data_word))
        else $error("time tag load without matching data word");
    a_host_no_load: assert property (mode_data_valid && sync_load_option == 2'b00 |=> !time_tag_load)
        else $error("time tag loaded under host option");
    a_lo_gate_load: assert property (mode_data_valid && sync_load_option == 2'b01 && mode_data_word[0] |=> !time_tag_load)
        else $error("load with bit 0 high under option 01");
    a_hi_gate_load: assert property (mode_data_valid && sync_load_option == 2'b10 && !mode_data_word[0] |=> !time_tag_load)
        else $error("load with bit 0 low under option 10");
    a_go_not_early: assert property (time_tag_load |-> !$past(status_tx_go))
        else $error("status released before time tag load");
    a_src_cause: assert property (service_request_clear |-> $past(cmd.valid) && !$past(vector_word_option))
        else $error("service request clear without cause");
    a_src_fires: assert property (cmd.valid && cmd.word[10:0] == 11'h410 && !vector_word_option |=> service_request_clear)
        else $error("vector command did not clear service request");
    a_reset_option: assert property (soft_reset_signal |-> !reset_command_option)
        else $error("soft reset under host reset option");
    a_reserved_zero: assert property (host_rdata[8:6] == 3'h0 && host_rdata[1:0] == 2'h0)
        else $error("reserved bits read nonzero");
    a_parity_flag: assert property ($past(host_req.rd) && $past(host_req.addr) == 8'h18 |-> host_rdata[2] == ~^host_rdata[15:10])
        else $error("parity fail bit wrong");
    cover property (time_tag_load ##1 status_tx_go);
    cover property (service_request_clear);
    cover property (soft_reset_signal);
endmodule

bind rtmc_mode_status rtmc_mode_status_mon mon_u (.clock, .rstn, .sync_load_option, .vector_word_option,
    .reset_command_option, .host_req, .host_rdata, .cmd, .mode_data_valid, .mode_data_word, .status_tx_go,
    .time_tag_load, .time_tag_value, .service_request_clear, .soft_reset_signal);

//--- rtmc_engine_model.sv
module rtmc_engine_model (
    input wire logic clock,
    output rtmc_pkg::rtmc_cmd_t cmd,
    output logic mode_data_valid,
    output logic [15:0] mode_data_word,
    output logic status_tx_req,
    output logic status_tx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // one-cycle strobes, called at a falling edge
    // ----------------------------------------
    // idle word lines show the inverse of the last value, so no stale match
    initial begin
        cmd = '0;
        mode_data_valid = 1'b0;
        mode_data_word = 16'h0000;
        status_tx_req = 1'b0;
        status_tx_done = 1'b0;
    end
    task automatic send_cmd(input logic [15:0] w, input logic bc);
        cmd = '{valid: 1'b1, broadcast: bc, word: w};
        @(negedge clock);
        cmd = '{valid: 1'b0, broadcast: ~bc, word: ~w};
    endtask
    task automatic send_data(input logic [15:0] w);
        mode_data_valid = 1'b1;
        mode_data_word = w;
        @(negedge clock);
        mode_data_valid = 1'b0;
        mode_data_word = ~w;
    endtask
    task automatic tx_req();
        status_tx_req = 1'b1;
        @(negedge clock);
        status_tx_req = 1'b0;
    endtask
    task automatic tx_done();
        status_tx_done = 1'b1;
        @(negedge clock);
        status_tx_done = 1'b0;
    endtask
endmodule

//--- tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] terminal_address_bits = 5'h00;
    logic terminal_address_parity = 1'b0, address_lock_pin = 1'b0;
    logic vector_word_option = 1'b0, reset_command_option = 1'b0;
    logic [1:0] sync_load_option = 2'h0;
    rtmc_pkg::rtmc_host_req_t host_req = '0;
    rtmc_pkg::rtmc_cmd_t cmd;
    logic mode_data_valid, status_tx_req, status_tx_done, status_tx_go, time_tag_load;
    logic service_request_clear, soft_reset_signal;
    logic [15:0] mode_data_word, host_rdata, time_tag_value, rd_v;
    logic [5:0] terminal_address_out;
    int mismatches = 0, n_compared = 0, cycles = 0;
    rtmc_mode_status dut_u (.clock, .rstn, .terminal_address_bits, .terminal_address_parity, .address_lock_pin,
        .sync_load_option, .vector_word_option, .reset_command_option, .host_req, .host_rdata, .cmd,
        .mode_data_valid, .mode_data_word, .status_tx_req, .status_tx_done, .status_tx_go, .time_tag_load,
        .time_tag_value, .service_request_clear, .soft_reset_signal, .terminal_address_out);
    rtmc_engine_model eng_u (.clock, .cmd, .mode_data_valid, .mode_data_word, .status_tx_req, .status_tx_done);
    // ----------------------------------------
    // clock, watchdog, helpers
    // ----------------------------------------
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
        host_req.rd = 1'b1;
        host_req.addr = a;
        @(negedge clock);
        v = host_rdata;
        host_req.rd = 1'b0;
    endtask
    task automatic reg_wr(input logic [15:0] v);
        host_req.wr = 1'b1;
        host_req.addr = 8'h18;
        host_req.wdata = v;
        @(negedge clock);
        host_req.wr = 1'b0;
    endtask
    task automatic do_reset(input logic [6:0] straps);
        rstn = 1'b0;
        {terminal_address_bits, terminal_address_parity, address_lock_pin} = straps;
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_lock();
        do_reset(7'h55);
        reg_rd(8'h18, rd_v);
        chk(rd_v, 16'haa00);
        chk({10'h0, terminal_address_out}, 16'h002a);
        reg_wr(16'hffff);
        reg_rd(8'h18, rd_v);
        chk(rd_v, 16'haa00);
        do_reset(7'h56);
        reg_rd(8'h18, rd_v);
        chk(rd_v, 16'hac04);
        reg_wr(16'h57ff);
        reg_rd(8'h18, rd_v);
        chk(rd_v, 16'h5600);
        reg_wr(16'h0000);
        reg_rd(8'h19, rd_v);
        chk(rd_v, 16'h0000);
        reg_rd(8'h18, rd_v);
        chk(rd_v, 16'h5600);
    endtask
    task automatic t_sync();
        logic [15:0] w;
        logic exp, go;
        for (int i = 0; i < 8; i++) begin
            sync_load_option = i[2:1];
            w = i[0] ? 16'h4321 : 16'h1234;
            exp = (i[2:1] == 2'b11) || (i[2:1] == 2'b01 && !w[0]) || (i[2:1] == 2'b10 && w[0]);
            eng_u.send_cmd(16'h0011, 1'b0);
            eng_u.tx_req();
            go = status_tx_go;
            if (exp) chk({15'h0, go}, 16'h0);
            eng_u.send_data(w);
            if (exp) chk({15'h0, status_tx_go}, 16'h0);
            chk({15'h0, time_tag_load}, {15'h0, exp});
            if (exp) chk(time_tag_value, w);
            // status leaves the edge after the data word, whatever the option
            @(negedge clock);
            chk({15'h0, status_tx_go}, 16'h1);
        end
    endtask
    task automatic t_vec();
        for (int i = 0; i < 4; i++) begin
            vector_word_option = i[0];
            eng_u.send_cmd(i[1] ? 16'h07f0 : 16'h0410, 1'b0);
            chk({15'h0, service_request_clear}, {15'h0, ~i[0]});
            @(negedge clock);
        end
    endtask
    task automatic t_rst();
        logic [15:0] n;
        reset_command_option = 1'b0;
        eng_u.send_cmd(16'h0408, 1'b0);
        repeat (3) @(negedge clock);
        chk({15'h0, soft_reset_signal}, 16'h0);
        eng_u.tx_done();
        chk({15'h0, soft_reset_signal}, 16'h1);
        // a command in the firing cycle is not taken
        @(negedge clock);
        for (int r = 0; r < 2; r++) begin
            reset_command_option = r[0];
            eng_u.send_cmd(16'h0408, 1'b1);
            n = 16'h0;
            repeat (4) begin
                n = n + {15'h0, soft_reset_signal};
                @(negedge clock);
            end
            chk(n, {15'h0, ~r[0]});
        end
    endtask
    task automatic t_type();
        logic [15:0] words [5] = '{16'h0021, 16'h0401, 16'h0011, 16'h0410, 16'h0001};
        logic [2:0] kinds [5] = '{3'b000, 3'b100, 3'b010, 3'b001, 3'b111};
        for (int i = 0; i < 5; i++) begin
            eng_u.send_cmd(words[i], 1'b0);
            // flags land on the 125th edge; read one edge before and after
            repeat (123) @(negedge clock);
            reg_rd(8'h18, rd_v);
            if (i > 0) chk({13'h0, rd_v[5:3]}, {13'h0, kinds[i-1]});
            @(negedge clock);
            reg_rd(8'h18, rd_v);
            chk({13'h0, rd_v[5:3]}, {13'h0, kinds[i]});
        end
    endtask
    initial begin
        t_lock();
        t_sync();
        t_vec();
        t_rst();
        t_type();
        stop_test();
    end
endmodule
